//--- scs_pkg.sv
// shared constants and types of the conversion sequencer
package scs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // resolution and output codes
  localparam int RES_BITS = 16;
  localparam logic [15:0] CODE_ALL_ZEROS = 16'h0000;
  localparam logic [15:0] CODE_MIDSCALE = 16'h8000;
  localparam logic [15:0] CODE_ALL_ONES = 16'hffff;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // timing: clock rate and documented analog phase times
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ACQ_TIME_NS = 1800;
  localparam int CONV_MAX_NS = 3200;
  // least time rounds up
  localparam int ACQ_CYCLES =
    (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // longest time rounds down
  localparam int CONV_MAX_CYCLES = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int ACQ_CNT_BITS = 10;

  ////////////////////////////////////////////////////////////////////////////
  // internal conversion clock: system cycles per bit decision
  localparam int CONV_DIV = 8;
  // sequencer cycles outside the bit decisions
  localparam int SEQ_OVERHEAD = 3;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [2:0] {
    ST_ACQ,
    ST_OPEN_SW,
    ST_GND_ARRAY,
    ST_RESOLVE,
    ST_PWR_DOWN
  } scs_state_t;

endpackage : scs_pkg

//--- scs_conv_clk.sv
// internal conversion clock: one step pulse every DIV cycles while enabled
module scs_conv_clk
  import scs_pkg::*;
#(
  parameter int DIV = CONV_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic en,
  output logic tick
);

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  if (DIV < 2) begin : g_div_check
    $error("scs_conv_clk: DIV must be at least 2");
  end

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;

  ////////////////////////////////////////////////////////////////////////////
  // divider restarts whenever the enable drops
  always_comb begin
    next_cnt = '0;
    next_tick = 1'b0;
    if (en) begin
      next_cnt = (cnt == LAST) ? '0 : cnt + ONE;
      next_tick = (cnt == LAST); // RULE_06
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step pulses are single cycles, never back to back
  tick_single_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    tick |=> !tick)
    else $error("conversion clock tick lasted more than one cycle");

endmodule : scs_conv_clk

//--- scs_sar_reg.sv
// successive approximation register: trial word and bit pointer
module scs_sar_reg
  import scs_pkg::*;
#(
  parameter int WIDTH = RES_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic step,
  input wire logic comp_high,
  // state
  output logic [WIDTH-1:0] trial,
  output logic last
);

  if (WIDTH < 2) begin : g_width_check
    $error("scs_sar_reg: WIDTH must be at least 2");
  end

  // one-hot word holding only the most significant bit
  function automatic logic [WIDTH-1:0] msb_only();
    return {1'b1, {(WIDTH - 1){1'b0}}};
  endfunction : msb_only

  logic [WIDTH-1:0] mask;
  logic [WIDTH-1:0] next_mask;
  logic [WIDTH-1:0] next_trial;
  logic [WIDTH-1:0] kept;

  ////////////////////////////////////////////////////////////////////////////
  // decide the bit under test, then try the next lower weight
  always_comb begin
    kept = comp_high ? trial : (trial & ~mask);
    next_mask = mask;
    next_trial = trial;
    if (load) begin
      next_mask = msb_only(); // RULE_03
      next_trial = msb_only();
    end else if (step && (mask != '0)) begin
      next_mask = mask >> 1; // RULE_03
      next_trial = kept | (mask >> 1);
    end
  end

  assign last = step && mask[0] && !load;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= '0;
      trial <= '0;
    end else begin
      mask <= next_mask;
      trial <= next_trial;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a load always starts from the half-reference trial
  load_msb_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    load |=> (trial == msb_only()) && (mask == msb_only()))
    else $error("trial word did not start at the most significant bit");

endmodule : scs_sar_reg

//--- sar_conversion_sequencer.sv
// control sequencer of a 16-bit successive approximation converter
//
// Summary of operation
// RULE_01 - a rising convert start after acquisition has run its time begins a conversion.
// RULE_02 - conversion opens the ground switches first, then moves both arrays to ground.
// RULE_03 - sixteen binary weighted decisions resolve the sample, most significant first.
// RULE_04 - after the last decision the core powers down and returns to acquisition alone.
// RULE_05 - at completion the code is produced and the busy indication falls with a done pulse.
// RULE_06 - bit decisions are paced by an internal conversion clock, not by any serial clock.
// RULE_07 - the result presented belongs to the conversion that just finished.
// RULE_08 - the host keeps its average start rate at or below 250 kSPS.
// RULE_09 - the output word is straight binary, midscale reading 8000.
// RULE_10 - an input above the reference span reads as the all-ones code.
// RULE_11 - an input below ground reads as the all-zeros code.
// RULE_12 - the result stays stable until the next conversion replaces it.
module sar_conversion_sequencer
  import scs_pkg::*;
#(
  parameter int DIV = CONV_DIV
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // host request
  input wire logic CONVERT_START,
  // analog front end status
  input wire logic COMP_HIGH,
  input wire logic OVER_RANGE,
  input wire logic UNDER_RANGE,
  // switch and array control
  output logic POS_GROUND_SWITCH,
  output logic NEG_GROUND_SWITCH,
  output logic ARRAY_ON_INPUT,
  output logic [15:0] DAC_SWITCH,
  output logic POWER_UP,
  // result toward the readout port
  output logic BUSY,
  output logic CONV_DONE,
  output logic RESULT_VALID,
  output logic [15:0] RESULT
);

  localparam int RESOLVE_MAX = RES_BITS * DIV + 2;
  localparam logic [ACQ_CNT_BITS-1:0] ACQ_DONE_CNT = ACQ_CNT_BITS'(ACQ_CYCLES);
  localparam logic [ACQ_CNT_BITS-1:0] ACQ_ONE = ACQ_CNT_BITS'(1);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (RES_BITS * DIV + SEQ_OVERHEAD > CONV_MAX_CYCLES) begin : g_time_check
    $error("sequencer: DIV too large for the longest conversion time");
  end
  if (ACQ_CYCLES >= (1 << ACQ_CNT_BITS)) begin : g_acq_check
    $error("sequencer: acquisition counter too narrow");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  scs_state_t state;
  scs_state_t next_state;
  logic start_prev;
  logic start_rise;
  logic [ACQ_CNT_BITS-1:0] acq_cnt;
  logic [ACQ_CNT_BITS-1:0] next_acq_cnt;
  logic acq_done;
  logic clamp_hi;
  logic clamp_lo;
  logic next_clamp_hi;
  logic next_clamp_lo;
  logic step;
  logic tick;
  logic last_step;
  logic sar_load;
  logic [15:0] sar_trial;
  logic next_pos_sw;
  logic next_neg_sw;
  logic next_array_in;
  logic next_power_up;
  logic next_busy;
  logic next_done;
  logic next_valid;
  logic [15:0] next_result;

  ////////////////////////////////////////////////////////////////////////////
  // internal conversion clock and approximation register
  assign step = tick && (state == ST_RESOLVE);
  assign sar_load = (state == ST_GND_ARRAY);

  scs_conv_clk #(
    .DIV(DIV)
  ) u_conv_clk (
    .clk(CLK),
    .rst_n(rst_n),
    .en(state == ST_RESOLVE), // RULE_06
    .tick(tick)
  );

  scs_sar_reg #(
    .WIDTH(RES_BITS)
  ) u_sar (
    .clk(CLK),
    .rst_n(rst_n),
    .load(sar_load),
    .step(step),
    .comp_high(COMP_HIGH),
    .trial(sar_trial),
    .last(last_step)
  );

  ////////////////////////////////////////////////////////////////////////////
  // start edge and acquisition timer
  assign start_rise = CONVERT_START && !start_prev;
  assign acq_done = (acq_cnt == ACQ_DONE_CNT);

  always_comb begin
    next_acq_cnt = '0;
    if (state == ST_ACQ) begin
      next_acq_cnt = acq_done ? acq_cnt : acq_cnt + ACQ_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state and clamp capture
  always_comb begin
    next_state = state;
    next_clamp_hi = clamp_hi;
    next_clamp_lo = clamp_lo;
    case (state)
      ST_ACQ: begin
        if (start_rise && acq_done) begin
          next_state = ST_OPEN_SW; // RULE_01
          next_clamp_hi = OVER_RANGE;
          next_clamp_lo = UNDER_RANGE && !OVER_RANGE;
        end
      end
      ST_OPEN_SW: begin
        next_state = ST_GND_ARRAY; // RULE_02
      end
      ST_GND_ARRAY: begin
        next_state = ST_RESOLVE;
      end
      ST_RESOLVE: begin
        if (last_step) begin
          next_state = ST_PWR_DOWN;
        end
      end
      ST_PWR_DOWN: begin
        next_state = ST_ACQ; // RULE_04
      end
      default: begin
        next_state = ST_ACQ;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output values follow the next state so every output is a flip-flop
  always_comb begin
    next_pos_sw = 1'b1;
    next_neg_sw = 1'b1;
    next_array_in = 1'b1;
    next_power_up = 1'b0;
    next_busy = 1'b0;
    case (next_state)
      ST_OPEN_SW: begin
        next_pos_sw = 1'b0; // RULE_02
        next_neg_sw = 1'b0;
        next_power_up = 1'b1;
        next_busy = 1'b1;
      end
      ST_GND_ARRAY, ST_RESOLVE: begin
        next_pos_sw = 1'b0;
        next_neg_sw = 1'b0;
        next_array_in = 1'b0; // RULE_02
        next_power_up = 1'b1;
        next_busy = 1'b1;
      end
      ST_PWR_DOWN: begin
        next_pos_sw = 1'b0;
        next_neg_sw = 1'b0;
        next_array_in = 1'b0;
      end
      default: begin
        next_pos_sw = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // result: straight binary, clamped at the end codes, held until replaced
  always_comb begin
    next_done = 1'b0;
    next_valid = RESULT_VALID;
    next_result = RESULT; // RULE_12
    if (state == ST_RESOLVE && last_step) begin
      next_done = 1'b1; // RULE_05
      next_valid = 1'b1;
      if (clamp_hi) begin
        next_result = CODE_ALL_ONES; // RULE_10
      end else if (clamp_lo) begin
        next_result = CODE_ALL_ZEROS; // RULE_11
      end else begin
        // the lowest bit is decided by this very tick's comparator
        next_result = {sar_trial[15:1], COMP_HIGH}; // RULE_07 RULE_09
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_ACQ;
      start_prev <= 1'b0;
      acq_cnt <= '0;
      clamp_hi <= 1'b0;
      clamp_lo <= 1'b0;
      POS_GROUND_SWITCH <= 1'b1;
      NEG_GROUND_SWITCH <= 1'b1;
      ARRAY_ON_INPUT <= 1'b1;
      POWER_UP <= 1'b0;
      BUSY <= 1'b0;
      CONV_DONE <= 1'b0;
      RESULT_VALID <= 1'b0;
      RESULT <= RESULT_RESET;
    end else begin
      state <= next_state;
      start_prev <= CONVERT_START;
      acq_cnt <= next_acq_cnt;
      clamp_hi <= next_clamp_hi;
      clamp_lo <= next_clamp_lo;
      POS_GROUND_SWITCH <= next_pos_sw;
      NEG_GROUND_SWITCH <= next_neg_sw;
      ARRAY_ON_INPUT <= next_array_in;
      POWER_UP <= next_power_up;
      BUSY <= next_busy;
      CONV_DONE <= next_done;
      RESULT_VALID <= next_valid;
      RESULT <= next_result;
    end
  end

  assign DAC_SWITCH = sar_trial;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  start_accept_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_01
    (state == ST_ACQ && start_rise && acq_done) |=>
      (state == ST_OPEN_SW) && BUSY && POWER_UP)
    else $error("qualified start did not begin a conversion");

  early_start_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_01
    (state == ST_ACQ && !acq_done) |=> (state == ST_ACQ))
    else $error("conversion began before acquisition ended");

  switch_order_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_02
    (state == ST_OPEN_SW) |->
      (!POS_GROUND_SWITCH && !NEG_GROUND_SWITCH && ARRAY_ON_INPUT)
      ##1 (!POS_GROUND_SWITCH && !ARRAY_ON_INPUT))
    else $error("ground switches and arrays switched out of order");

  msb_first_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_03
    $rose(state == ST_RESOLVE) |-> (DAC_SWITCH == CODE_MIDSCALE))
    else $error("first trial was not the half-reference weight");

  resolve_len_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_06
    $rose(state == ST_RESOLVE) |-> ##[1:RESOLVE_MAX] CONV_DONE)
    else $error("bit decisions did not finish in time");

  power_down_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_04
    CONV_DONE |-> !POWER_UP ##1 (state == ST_ACQ) && ARRAY_ON_INPUT
      && POS_GROUND_SWITCH && NEG_GROUND_SWITCH)
    else $error("core did not power down and return to acquisition");

  done_busy_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_05
    CONV_DONE |-> !BUSY && $past(BUSY) && RESULT_VALID)
    else $error("done pulse not aligned with busy falling");

  fresh_result_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_07
    (CONV_DONE && !clamp_hi && !clamp_lo) |-> (RESULT == DAC_SWITCH))
    else $error("result does not match the conversion just made");

  over_clamp_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_10
    (CONV_DONE && clamp_hi) |-> (RESULT == CODE_ALL_ONES))
    else $error("overrange did not saturate high");

  under_clamp_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_11
    (CONV_DONE && clamp_lo) |-> (RESULT == CODE_ALL_ZEROS))
    else $error("underrange did not saturate low");

  result_hold_a: assert property (@(posedge CLK) disable iff (!rst_n) // RULE_12
    (!CONV_DONE && $past(rst_n)) |-> $stable(RESULT))
    else $error("result changed without a new conversion");

  cover_conv_c: cover property (@(posedge CLK) disable iff (!rst_n)
    CONV_DONE && !clamp_hi && !clamp_lo);
  cover_over_c: cover property (@(posedge CLK) disable iff (!rst_n)
    CONV_DONE && clamp_hi);
  cover_under_c: cover property (@(posedge CLK) disable iff (!rst_n)
    CONV_DONE && clamp_lo);
  cover_ignored_c: cover property (@(posedge CLK) disable iff (!rst_n)
    start_rise && (state != ST_ACQ));

endmodule : sar_conversion_sequencer

//--- scs_host_model.sv
// host and analog front end model facing the conversion sequencer
module scs_host_model
  import scs_pkg::*;
(
  // clock
  input wire logic clk,
  // trial word from the sequencer
  input wire logic [15:0] dac,
  // host request and analog status
  output logic start,
  output logic comp_high,
  output logic over,
  output logic under
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sample = 16'h0000;
  int cyc = 0;
  int last = 0;
  initial begin
    start = 1'b0;
    over = 1'b0;
    under = 1'b0;
  end
  // free running cycle count used to space the requests
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end
  // comparator: keep the trial bit while it does not pass the sample
  always_comb begin
    comp_high = (dac <= sample);
  end
  // one start request, held a few cycles as a level
  task automatic convert(input logic [15:0] s, input logic ov,
                         input logic un);
    @(negedge clk);
    while (cyc - last < 1000) @(negedge clk);
    sample = s;
    over = ov;
    under = un;
    start = 1'b1;
    last = cyc;
    repeat (4) @(negedge clk);
    start = 1'b0;
  endtask : convert
  // short pulse that the sequencer is expected to ignore
  task automatic stray();
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask : stray
endmodule : scs_host_model

//--- tb.sv
// self-checking bench of the conversion sequencer
module tb
  import scs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIVS = 2;
  // busy spans the switch steps plus every bit decision
  localparam int BUSY_LEN = SEQ_OVERHEAD + RES_BITS * DIVS;
  localparam int LIMIT = 20000;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic start, comp_high, over, under;
  logic pos_sw, neg_sw, on_input, power_up, busy, done, valid;
  logic [15:0] dac, result, held;
  logic [15:0] exp_q[$];
  logic [15:0] pts[6];
  logic [31:0] rng = 32'h6ad522d5;
  logic busy_d = 1'b0;
  logic done_d = 1'b0;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  int busy_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, timeout and instances
  always #2 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles >= LIMIT) begin
      err_total++;
      wrap_up();
    end
  end
  sar_conversion_sequencer #(.DIV(DIVS)) dut (
    .CLK(CLK), .NRST(NRST), .CONVERT_START(start), .COMP_HIGH(comp_high),
    .OVER_RANGE(over), .UNDER_RANGE(under), .POS_GROUND_SWITCH(pos_sw),
    .NEG_GROUND_SWITCH(neg_sw), .ARRAY_ON_INPUT(on_input),
    .DAC_SWITCH(dac), .POWER_UP(power_up), .BUSY(busy), .CONV_DONE(done),
    .RESULT_VALID(valid), .RESULT(result));
  scs_host_model host (
    .clk(CLK), .dac(dac), .start(start), .comp_high(comp_high),
    .over(over), .under(under));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic check(input logic [15:0] seen, input logic [15:0] want,
                       input string what);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // note the expected code, then request one conversion
  task automatic run(input logic [15:0] s, input logic ov, input logic un,
                     input logic [15:0] want);
    exp_q.push_back(want);
    host.convert(s, ov, un);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  // output watcher: compares each completion with the oldest note
  always @(negedge CLK) begin
    if (NRST === 1'b1) begin
      if (busy === 1'b1) begin
        busy_cnt++;
        check(16'(power_up), 16'h0001, "power during conversion");
      end
      if (on_input === 1'b0) begin
        check(16'(pos_sw | neg_sw), 16'h0000, "switch order");
      end
      if (busy === 1'b1 && busy_d === 1'b0) begin
        check(16'(on_input), 16'h0001, "arrays moved early");
      end
      if (done_d === 1'b1) begin
        check(16'({pos_sw, neg_sw, on_input}), 16'h0007, "no return");
      end
      if (done === 1'b1) begin
        if (exp_q.size() == 0) begin
          check(16'h0001, 16'h0000, "unexpected completion");
        end else begin
          check(result, exp_q.pop_front(), "result code");
        end
        check(16'(busy_cnt), 16'(BUSY_LEN), "conversion length");
        check(16'({busy, power_up}), 16'h0000, "busy at end");
        check(16'(valid), 16'h0001, "valid flag");
        busy_cnt = 0;
        held = result;
      end else begin
        check(result, held, "result moved");
      end
      busy_d = busy;
      done_d = done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    held = RESULT_RESET;
    pts = '{16'h0000, 16'h8000, 16'h7fff, 16'h8001, 16'hffff, 16'h0001};
    repeat (2) @(negedge CLK);
    NRST = 1'b1;
    @(negedge CLK);
    check(result, RESULT_RESET, "reset result");
    check(16'({valid, busy}), 16'h0000, "reset flags");
    // end codes and the codes around midscale
    foreach (pts[i]) begin
      run(pts[i], 1'b0, 1'b0, pts[i]);
    end
    run(16'h1234, 1'b1, 1'b0, CODE_ALL_ONES);
    run(16'h5555, 1'b0, 1'b1, CODE_ALL_ZEROS);
    run(16'h0000, 1'b1, 1'b1, CODE_ALL_ONES);
    // starts while busy and during acquisition are ignored
    run(16'h00ff, 1'b0, 1'b0, 16'h00ff);
    host.stray();
    repeat (60) @(negedge CLK);
    host.stray();
    // random samples
    repeat (4) begin
      rng = xorshift(rng);
      run(rng[15:0], 1'b0, 1'b0, rng[15:0]);
    end
    repeat (1100) @(negedge CLK);
    check(16'(exp_q.size()), 16'h0000, "missing completions");
    wrap_up();
  end
endmodule : tb
